// ==== bench/shfs_checker_assertions.sv ====
// port checker of the serializer, bound into every instance
// assumes the register map and marker timing of shfs_pkg
`timescale 1ns/1ps
module shfs_checker #(
  parameter int BIT_DIV = 2  // system cycles per fast bit
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData_r,
  // frame timing and link
  input wire logic        sensorFrameStart,
  input wire logic        serial_lane0_r,
  input wire logic        serialClk_r,
  input wire logic        frameMarker_r
);
  localparam int MK_LO = 8 * BIT_DIV - 1;  // marker cycles, lower bound
  localparam int MK_HI = 8 * BIT_DIV + 1;  // marker cycles, upper bound
  logic [2:0] ctrl_r;   // control value as last written
  int         mkCnt_r;  // marker high cycles so far
  // follow control writes and count marker cycles
  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_r <= 3'h4;
    else if (regWr && regAddr == 8'h00)
      ctrl_r <= regWrData[2:0];
    mkCnt_r <= (reset || !frameMarker_r) ? 0 : mkCnt_r + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_read_idle_zero: assert property (!regRd |=> regRdData_r == 32'h0000_0000)
    else $error("read data not zero outside read");
  a_unmapped_read: assert property (regRd && regAddr == 8'h14 |=> regRdData_r == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (regRd && regAddr == 8'h00 |=> regRdData_r[2:0] == ctrl_r)
    else $error("control read differs from write");
  a_marker_start: assert property (sensorFrameStart && ctrl_r[2] |-> ##[1:6] $rose(frameMarker_r))
    else $error("no marker after frame start");
  a_marker_length: assert property ($fell(frameMarker_r) |-> mkCnt_r >= MK_LO && mkCnt_r <= MK_HI)
    else $error("marker length wrong");
  a_lane0_single: assert property (sensorFrameStart && ctrl_r[2] && !ctrl_r[1] |-> ##6 (!serial_lane0_r) [*8])
    else $error("lane 0 active in single lane mode");
  a_clock_runs: assert property (1'b1 |-> ##[1:3] serialClk_r != $past(serialClk_r))
    else $error("forwarded clock stopped");
  a_disabled_quiet: assert property (sensorFrameStart && !ctrl_r[2] && !frameMarker_r |=> (!frameMarker_r) [*8])
    else $error("frame started while disabled");
endmodule : shfs_checker
bind shfs_serializer shfs_checker #(.BIT_DIV(BIT_DIV)) i_chk (.clk, .reset, .regAddr, .regWrData,
  .regWr, .regRd, .regRdData_r, .sensorFrameStart, .serial_lane0_r, .serialClk_r, .frameMarker_r);

// ==== bench/shfs_rx_model.sv ====
// receiver model: rebuilds 16-bit words of both lanes per frame
// assumes lanes and clock are registered on the system clock
`timescale 1ns/1ps
module shfs_rx_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial link
  input wire logic serialClk,
  input wire logic lane0,
  input wire logic lane1,
  input wire logic marker
);
  logic        clkPrev, mkPrev;  // last samples
  int          bitIdx, frames;   // bit position, frames seen
  logic [15:0] w0 [32];          // lane 0 words
  logic [15:0] w1 [32];          // lane 1 words
  // sample on rising link clock, realign on marker rise
  always @(posedge clk)
  begin
    clkPrev <= reset ? 1'b0 : serialClk;
    if (reset)
      frames <= 0;
    else if (serialClk && !clkPrev)
    begin
      mkPrev <= marker;
      if (marker && !mkPrev)
      begin
        bitIdx <= 1;
        frames <= frames + 1;
        w0[0][0] <= lane0;
        w1[0][0] <= lane1;
      end
      else if (bitIdx < 512)
      begin
        w0[bitIdx / 16][bitIdx % 16] <= lane0;
        w1[bitIdx / 16][bitIdx % 16] <= lane1;
        bitIdx <= bitIdx + 1;
      end
    end
  end
endmodule : shfs_rx_model

// ==== bench/sparse_hit_frame_serializer_tb_top.sv ====
// self-checking bench: register tasks, hit feeding, frame capture
// assumes BIT_DIV of 2 and the receiver model beside the design
`timescale 1ns/1ps
module sparse_hit_frame_serializer_tb_top;
  logic clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, sensorFrameStart = 1'b0;
  logic lineValid = 1'b0, runValid = 1'b0, lineOverflow = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000, regRdData_r;
  logic [9:0]  lineRow = 10'h000, runCol = 10'h000;
  logic [3:0]  lineRuns = 4'h0;
  logic [1:0]  runLen = 2'h0;
  logic        serial_lane0_r, serial_lane1_r, serialClk_r, frameMarker_r;
  int          bad_count = 0, checks_done = 0, frames = 0;
  logic [15:0] expF1 [11] = '{16'h1E0F, 16'hC3A5, 16'h0001, 16'h0000, 16'h0003, 16'h0003,
                             16'hD551, 16'h0AAB, 16'h0031, 16'h0005, 16'h0000};
  always #10 clk = ~clk;
  shfs_serializer #(.BIT_DIV(2)) i_dut (.clk, .reset, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData_r, .sensorFrameStart, .lineValid, .lineRow, .lineRuns, .lineOverflow, .runValid,
    .runCol, .runLen, .serial_lane0_r, .serial_lane1_r, .serialClk_r, .frameMarker_r);
  shfs_rx_model i_rx (.clk, .reset, .serialClk(serialClk_r), .lane0(serial_lane0_r),
    .lane1(serial_lane1_r), .marker(frameMarker_r));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("register", exp, regRdData_r & m);
  endtask : rd
  task automatic start(input int words);
    int n = 0;
    @(posedge clk);
    sensorFrameStart <= 1'b1;
    @(posedge clk);
    sensorFrameStart <= 1'b0;
    if (words > 0)
      frames++;
    while (words > 0 && (i_rx.frames != frames || i_rx.bitIdx < 16 * words))
    begin
      @(posedge clk);
      n++;
      if (n > 4000)
      begin
        bad_count++;
        report_and_stop();
      end
    end
  endtask : start
  task automatic hit(input logic ln, input logic [9:0] a, input logic [3:0] n, input logic o);
    lineValid <= ln;
    runValid <= !ln;
    lineRow <= a;
    runCol <= a;
    lineRuns <= n;
    runLen <= n[1:0];
    lineOverflow <= o;
    @(posedge clk);
  endtask : hit
  // main sequence: defaults, single slow, truncation, dual fast, dual slow, disabled
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(8'h00, 32'h0000_0004, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(8'h04, 32'hC3A5_1E0F);
    wr(8'h08, 32'h5A3C_F0E1);
    start(1);
    hit(1'b1, 10'h155, 4'h1, 1'b1);
    hit(1'b0, 10'h2AA, 4'h3, 1'b0);
    hit(1'b1, 10'h003, 4'h1, 1'b0);
    hit(1'b0, 10'h001, 4'h1, 1'b0);
    lineValid <= 1'b0;
    runValid <= 1'b0;
    start(11);
    for (int k = 0; k < 11; k++)
      chk("single lane word", {16'h0000, expF1[k]}, {16'h0000, i_rx.w1[k]});
    chk("lane 0 idle", 32'h0000_0000, {i_rx.w0[0], i_rx.w0[6]});
    wr(8'h00, 32'h0000_0005);
    repeat (1846) hit(1'b0, 10'h3FF, 4'h2, 1'b0);
    runValid <= 1'b0;
    start(6);
    chk("truncated length", 32'h039A_039A, {i_rx.w1[4], i_rx.w1[5]});
    rd(8'h10, 32'h0001_0000, 32'h0001_0000);
    wr(8'h00, 32'h0000_0007);
    rd(8'h00, 32'h0000_0007, 32'hFFFF_FFFF);
    start(3);
    chk("dual lane 0", 32'h1E0F_0003, {i_rx.w0[0], i_rx.w0[1]});
    chk("dual lane 1", 32'hC3A5_0000, {i_rx.w1[0], i_rx.w1[1]});
    chk("empty length", 32'h0000_0000, {i_rx.w0[2], i_rx.w1[2]});
    wr(8'h00, 32'h0000_0006);
    start(2);
    chk("slow dual", 32'h0004_C3A5, {i_rx.w0[1], i_rx.w1[0]});
    wr(8'h00, 32'h0000_0003);
    start(0);
    repeat (40) @(posedge clk);
    rd(8'h0C, 32'h0000_0005, 32'hFFFF_FFFF);
    report_and_stop();
  end
endmodule : sparse_hit_frame_serializer_tb_top

// ==== src/shfs_bit_timer.sv ====
// serial bit timer: one-cycle bit enables and the forwarded clock level.
// assumes one system clock; BIT_DIV system cycles make one fast bit.
`timescale 1ns/1ps
module shfs_bit_timer #(
  parameter int BIT_DIV = 2  // system cycles per fast bit, even
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // rate choice
  input  wire logic rateFast,
  // enables and clock
  output logic      bitTick,
  output logic      fastTick,
  output logic      fwdClk_r
);

  localparam int PH_W = $clog2(2 * BIT_DIV);
  localparam logic [PH_W-1:0] PH_LAST  = PH_W'(2 * BIT_DIV - 1);
  localparam logic [PH_W-1:0] PH_MID   = PH_W'(BIT_DIV - 1);
  localparam logic [PH_W-1:0] PH_BIT   = PH_W'(BIT_DIV);
  localparam logic [PH_W-1:0] PH_HALF  = PH_W'(BIT_DIV / 2);

  logic [PH_W-1:0] phase_r;   // position in one slow bit
  logic [PH_W-1:0] phase_nxt; // next position
  logic [PH_W-1:0] inFast;    // position in one fast bit
  logic            clkNxt;    // forwarded clock level next cycle

  assign phase_nxt = (phase_r == PH_LAST) ? '0 : phase_r + 1'b1;
  assign inFast    = (phase_nxt >= PH_BIT) ? phase_nxt - PH_BIT : phase_nxt;
  assign fastTick  = (phase_r == PH_LAST) || (phase_r == PH_MID);
  assign bitTick   = rateFast ? fastTick : (phase_r == PH_LAST);
  // low in the first half of a bit, rising mid-bit where data is stable
  assign clkNxt    = rateFast ? (inFast >= PH_HALF) : (phase_nxt >= PH_BIT);

  // free-running phase: the forwarded clock never stops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phase_r  <= '0;
      fwdClk_r <= 1'b0;
    end
    else
    begin
      phase_r  <= phase_nxt;
      fwdClk_r <= clkNxt;
    end
  end

endmodule : shfs_bit_timer

// ==== src/shfs_frame_store.sv ====
// two-bank payload store: one bank fills while the other is sent.
// assumes one writer and two synchronous readers on the same clock.
`timescale 1ns/1ps
module shfs_frame_store #(
  parameter int WIDTH  = 16,  // word width
  parameter int ADDR_W = 12   // word address width within one bank
) (
  // clock
  input  wire logic              clk,
  // write side
  input  wire logic              wrEn,
  input  wire logic              wrBank,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]  wrData,
  // read side
  input  wire logic              rdBank,
  input  wire logic [ADDR_W-1:0] rdAddrA,
  input  wire logic [ADDR_W-1:0] rdAddrB,
  output logic      [WIDTH-1:0]  rdDataA,
  output logic      [WIDTH-1:0]  rdDataB
);

  logic [WIDTH-1:0] mem [0:2**(ADDR_W+1)-1]; // both banks

  // write and read ports, data one cycle after the address
  always_ff @(posedge clk)
  begin
    if (wrEn)
      mem[{wrBank, wrAddr}] <= wrData;
    rdDataA <= mem[{rdBank, rdAddrA}];
    rdDataB <= mem[{rdBank, rdAddrB}];
  end

endmodule : shfs_frame_store

// ==== src/shfs_pkg.sv ====
// shared constants of the sparse hit frame serializer: word layout,
// frame geometry, register map and mode budgets.
// assumes nothing of its surroundings; used by name, never imported.
package shfs_pkg;

  // word and field layout
  localparam int WORD_W      = 16;   // serial word width
  localparam int CNT_W       = 32;   // frame counter width
  localparam int NUM_W       = 12;   // payload word count width
  localparam int ROW_W       = 10;   // hit row address width
  localparam int COL_W       = 10;   // hit column address width
  localparam int RUNS_W      = 4;    // run words per line width
  localparam int LEN_W       = 2;    // hit pixels per run width
  localparam int OVF_W       = 2;    // overflow flag copies in top bits
  localparam int PAD_W       = 4;    // zero bits on top of a run word
  localparam int BIT_LAST    = 15;   // index of the last bit of a word
  localparam int MARK_TICKS  = 8;    // marker length in fast bit times

  // frame geometry in words of one lane
  localparam int HDR_WORDS   = 3;    // open, count, length
  localparam int FRAME_NS    = 185600; // frame period, 185.6 us
  localparam int FAST_MHZ    = 160;  // fast serial rate
  localparam int SLOW_MHZ    = 80;   // slow serial rate
  localparam logic [NUM_W-1:0] SLOTS_FAST =
    NUM_W'(FRAME_NS * FAST_MHZ / 1000 / WORD_W);
  localparam logic [NUM_W-1:0] SLOTS_SLOW =
    NUM_W'(FRAME_NS * SLOW_MHZ / 1000 / WORD_W);

  // payload budgets in 16-bit words
  localparam logic [NUM_W-1:0] LIM_SINGLE_SLOW = 12'h1CB; // 459 per half
  localparam logic [NUM_W-1:0] LIM_DUAL_SLOW   = 12'h396; // 918 per lane
  localparam logic [NUM_W-1:0] LIM_SINGLE_FAST = 12'h39A; // 922 per half
  localparam logic [NUM_W-1:0] LIM_DUAL_FAST   = 12'h73A; // 1850 per lane

  // register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_OPEN   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CLOSE  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam int CTRL_W      = 3;
  localparam int CTRL_RATE   = 0;    // 1 = fast rate
  localparam int CTRL_DUAL   = 1;    // 1 = two lanes
  localparam int CTRL_EN     = 2;    // 1 = frames are sent
  localparam int STAT_TRUNC  = 16;   // last frame was cut short
  localparam logic [CTRL_W-1:0] CTRL_RST  = 3'h4;
  localparam logic [CNT_W-1:0]  MARK_RST  = 32'h0000_0000;

  // total payload budget of a mode, both lanes or halves together
  function automatic logic [NUM_W-1:0] payLimit(input logic rate, input logic dual);
    logic [NUM_W-1:0] half;
    half = rate ? (dual ? LIM_DUAL_FAST : LIM_SINGLE_FAST)
                : (dual ? LIM_DUAL_SLOW : LIM_SINGLE_SLOW);
    return NUM_W'(half << 1);
  endfunction : payLimit

endpackage : shfs_pkg

// ==== src/shfs_serializer.sv ====
// sparse hit frame serializer: stores the run-encoded hits of one sensor
// frame and sends them in the next one as a fixed-length serial frame.
// assumes hit inputs, frame start and register port share clk.
// Notes on behaviour
// - payload is line words followed by their runs
// - payload capped per mode, at most 3700 sixteen-bit words
// - excess payload is dropped, frame never grows
// - each sensor frame sends the previous frame's words
// - both lanes carry equal bit counts
// - even nonzero payload count below the budget gets one dummy run on lane 1
// - line word: runs, row, overflow on top
// - run word: length, column, four zero bits
// - word layouts identical in every mode
// - fixed frame length, unused slots sent as zeros
// - single lane slow: halves on lane 1, lane 0 zero
// - dual lane slow: low halves lane 0, high lane 1
// - single lane fast: whole frame on lane 1
// - dual lane fast: halves split over both lanes
// - forwarded clock runs always, rate changing only at an enabled frame start
// - words go out least significant bit first
// - marker high eight fast bit times at frame start
// - 32-bit wrapping frame counter sent as two halves
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module shfs_serializer #(
  parameter int BIT_DIV = 2  // system cycles per fast serial bit
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // register port
  input  wire logic [shfs_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [shfs_pkg::DATA_W-1:0] regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [shfs_pkg::DATA_W-1:0] regRdData_r,
  // sensor frame timing
  input  wire logic                        sensorFrameStart,
  // line descriptors from the suppression engine
  input  wire logic                        lineValid,
  input  wire logic [shfs_pkg::ROW_W-1:0]  lineRow,
  input  wire logic [shfs_pkg::RUNS_W-1:0] lineRuns,
  input  wire logic                        lineOverflow,
  // pixel runs from the suppression engine
  input  wire logic                        runValid,
  input  wire logic [shfs_pkg::COL_W-1:0]  runCol,
  input  wire logic [shfs_pkg::LEN_W-1:0]  runLen,
  // serial link
  output logic                             serial_lane0_r,
  output logic                             serial_lane1_r,
  output logic                             serialClk_r,
  output logic                             frameMarker_r
);

  localparam int NW = shfs_pkg::NUM_W;
  localparam int WW = shfs_pkg::WORD_W;
  localparam int CW = shfs_pkg::CNT_W;

  // control registers
  logic [shfs_pkg::CTRL_W-1:0] ctrl_r;         // rate, lanes, enable
  logic [CW-1:0]               openWord_r;     // frame_open_low/high
  logic [CW-1:0]               closeWord_r;    // frame_close_low/high
  // fill side
  logic                        wrBank_r;       // bank being filled
  logic [NW-1:0]               wrCount_r;      // words stored this frame
  logic                        wrTrunc_r;      // words lost this frame
  // send side snapshot
  logic [NW-1:0]               sendCount_r;    // words stored last frame
  logic                        sendTrunc_r;    // last frame was cut
  logic                        modeRate_r;     // rate of frame in flight
  logic                        modeDual_r;     // lanes of frame in flight
  logic [CW-1:0]               frameCount_r;   // frames since reset
  logic [CW-1:0]               countSent_r;    // counter value being sent
  // serialiser state
  logic                        startPend_r;    // frame waits for a bit edge
  logic                        active_r;       // frame slots in progress
  logic [NW-1:0]               slot_r;         // slot to load next
  logic [3:0]                  bitIdx_r;       // bit within current word
  logic [WW-1:0]               sh0_r;          // lane 0 shifter
  logic [WW-1:0]               sh1_r;          // lane 1 shifter
  logic [3:0]                  markCnt_r;      // marker fast bits left

  // timer and store wires
  logic          bitTick;    // one serial bit has passed
  logic          fastTick;   // one fast bit has passed
  logic [WW-1:0] memA;       // payload word for lane 1 / single lane
  logic [WW-1:0] memB;       // payload word for lane 0

  // bit enables and forwarded clock
  shfs_bit_timer #(
    .BIT_DIV (BIT_DIV)
  ) u_timer (
    .clk      (clk),
    .reset    (reset),
    .rateFast (modeRate_r),
    .bitTick  (bitTick),
    .fastTick (fastTick),
    .fwdClk_r (serialClk_r)
  );

  // hit word encoding, same layout in every mode
  logic [WW-1:0] lineWord;   // line descriptor word
  logic [WW-1:0] runWord;    // pixel run word
  logic [WW-1:0] wrWord;     // word offered to the store
  logic          wrReq;      // a word is offered
  logic          wrBankEff;  // bank for this cycle's word
  logic [NW-1:0] wrCountEff; // index for this cycle's word
  logic [NW-1:0] wrLimit;    // budget of the current mode
  logic          wrAccept;   // word fits in the budget
  assign lineWord   = {{shfs_pkg::OVF_W{lineOverflow}}, lineRow, lineRuns};
  assign runWord    = {{shfs_pkg::PAD_W{1'b0}}, runCol, runLen};
  assign wrWord     = lineValid ? lineWord : runWord;
  assign wrReq      = lineValid || runValid;
  // a word arriving with the frame start already belongs to the new frame
  assign wrBankEff  = sensorFrameStart ? ~wrBank_r : wrBank_r;
  assign wrCountEff = sensorFrameStart ? '0 : wrCount_r;
  assign wrLimit    = shfs_pkg::payLimit(ctrl_r[shfs_pkg::CTRL_RATE],
                                         ctrl_r[shfs_pkg::CTRL_DUAL]);
  assign wrAccept   = wrReq && (wrCountEff < wrLimit);

  // frame geometry of the frame in flight
  logic [NW-1:0] sendLimit;  // budget of the frame in flight
  logic          padNeed;    // even nonzero count below budget gets a dummy run
  logic [NW-1:0] totWords;   // payload words including the dummy
  logic [NW-1:0] laneLen;    // words per lane, or per half
  logic [NW-1:0] paySlots;   // slots holding payload on lane 1
  logic [NW-1:0] payStart;   // first payload slot
  logic [NW-1:0] frameSlots; // constant frame length in slots
  assign sendLimit  = shfs_pkg::payLimit(modeRate_r, modeDual_r);
  assign padNeed    = (sendCount_r != '0) && !sendCount_r[0]
                      && (sendCount_r < sendLimit);
  assign totWords   = sendCount_r + NW'(padNeed);
  assign laneLen    = NW'((totWords + 1'b1) >> 1);
  assign paySlots   = modeDual_r ? laneLen : NW'(laneLen << 1);
  assign payStart   = modeDual_r ? NW'(shfs_pkg::HDR_WORDS)
                                 : NW'(shfs_pkg::HDR_WORDS * 2);
  assign frameSlots = modeRate_r ? shfs_pkg::SLOTS_FAST : shfs_pkg::SLOTS_SLOW;

  // slot decode
  logic [NW-1:0] payOff;     // slot offset from payload start
  logic [NW-1:0] trlOff;     // slot offset from trailer start
  logic          inHdr;      // slot holds open, count or length
  logic          inPay;      // slot holds payload
  logic          inTrl;      // slot holds the trailer
  logic [NW-1:0] hdrField;   // which header field
  logic [NW-1:0] idxA;       // payload index for lane 1
  logic [NW-1:0] idxB;       // payload index for lane 0
  logic [CW-1:0] hdrVal;     // selected header field
  logic [CW-1:0] lenVal;     // length field, equal halves
  assign payOff   = slot_r - payStart;
  assign trlOff   = payOff - paySlots;
  assign inHdr    = active_r && (slot_r < payStart);
  assign inPay    = active_r && !inHdr && (payOff < paySlots);
  assign inTrl    = active_r && !inHdr && !inPay
                    && (trlOff < (modeDual_r ? NW'(1) : NW'(2)));
  assign hdrField = modeDual_r ? slot_r : NW'(slot_r >> 1);
  // dual lanes interleave: even words on lane 1, odd words on lane 0
  assign idxA     = modeDual_r ? NW'(payOff << 1) : payOff;
  assign idxB     = NW'((payOff << 1) + 1'b1);
  assign lenVal   = {{(CW/2-NW){1'b0}}, laneLen, {(CW/2-NW){1'b0}}, laneLen};
  assign hdrVal   = (hdrField == '0) ? openWord_r
                  : (hdrField == NW'(1)) ? countSent_r : lenVal;

  // payload store, the bank not being filled is read
  shfs_frame_store #(
    .WIDTH  (WW),
    .ADDR_W (NW)
  ) u_store (
    .clk     (clk),
    .wrEn    (wrAccept),
    .wrBank  (wrBankEff),
    .wrAddr  (wrCountEff),
    .wrData  (wrWord),
    .rdBank  (~wrBank_r),
    .rdAddrA (idxA),
    .rdAddrB (idxB),
    .rdDataA (memA),
    .rdDataB (memB)
  );

  // word selection per lane; anything outside a field is zero
  logic [WW-1:0] payA;       // lane 1 payload, zero past the count
  logic [WW-1:0] payB;       // lane 0 payload, zero past the count
  logic          hiHalf;     // single lane sends the high half now
  logic [WW-1:0] word0;      // next lane 0 word
  logic [WW-1:0] word1;      // next lane 1 word
  // the dummy run and the unused lane 0 slot read as zero words
  assign payA   = (idxA < sendCount_r) ? memA : '0;
  assign payB   = (idxB < sendCount_r) ? memB : '0;
  assign hiHalf = inTrl ? trlOff[0] : slot_r[0];
  assign word0  = !modeDual_r ? '0
                : inHdr ? hdrVal[WW-1:0]
                : inPay ? payB
                : inTrl ? closeWord_r[WW-1:0] : '0;
  assign word1  = inHdr ? ((modeDual_r || hiHalf) ? hdrVal[CW-1:WW] : hdrVal[WW-1:0])
                : inPay ? payA
                : inTrl ? ((modeDual_r || hiHalf) ? closeWord_r[CW-1:WW]
                                                  : closeWord_r[WW-1:0])
                : '0;

  // register decode
  logic          selCtrl;    // control register addressed
  logic          selOpen;    // open word addressed
  logic          selClose;   // close word addressed
  logic [CW-1:0] rdMux;      // read value of the addressed register
  assign selCtrl  = (regAddr == shfs_pkg::REG_CTRL);
  assign selOpen  = (regAddr == shfs_pkg::REG_OPEN);
  assign selClose = (regAddr == shfs_pkg::REG_CLOSE);
  assign rdMux    = selCtrl  ? CW'(ctrl_r)
                  : selOpen  ? openWord_r
                  : selClose ? closeWord_r
                  : (regAddr == shfs_pkg::REG_COUNT) ? frameCount_r
                  : (regAddr == shfs_pkg::REG_STATUS)
                    ? CW'({sendTrunc_r, {(shfs_pkg::STAT_TRUNC-NW){1'b0}}, sendCount_r})
                  : '0; // unmapped reads as zero

  logic          wordLoad;   // a new word enters the shifters
  assign wordLoad = bitTick && (startPend_r || (bitIdx_r == 4'(shfs_pkg::BIT_LAST)));

  // register writes and read data one cycle later
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_r      <= shfs_pkg::CTRL_RST;
      openWord_r  <= shfs_pkg::MARK_RST;
      closeWord_r <= shfs_pkg::MARK_RST;
      regRdData_r <= '0;
    end
    else
    begin
      if (regWr && selCtrl)
        ctrl_r <= regWrData[shfs_pkg::CTRL_W-1:0];
      if (regWr && selOpen)
        openWord_r <= regWrData;
      if (regWr && selClose)
        closeWord_r <= regWrData;
      regRdData_r <= regRd ? rdMux : '0;
    end
  end

  // fill side: count stored words, swap banks at each sensor frame
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wrBank_r  <= 1'b0;
      wrCount_r <= '0;
      wrTrunc_r <= 1'b0;
    end
    else
    begin
      wrBank_r  <= wrBankEff;
      wrCount_r <= wrCountEff + NW'(wrAccept);
      // a lost word in the start cycle belongs to the new frame
      wrTrunc_r <= (sensorFrameStart ? 1'b0 : wrTrunc_r) || (wrReq && !wrAccept);
    end
  end

  // send side snapshot and frame counter
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sendCount_r  <= '0;
      sendTrunc_r  <= 1'b0;
      modeRate_r   <= 1'b0;
      modeDual_r   <= 1'b0;
      frameCount_r <= '0;
      countSent_r  <= '0;
      startPend_r  <= 1'b0;
    end
    else if (sensorFrameStart && ctrl_r[shfs_pkg::CTRL_EN])
    begin
      sendCount_r  <= wrCount_r;
      sendTrunc_r  <= wrTrunc_r;
      modeRate_r   <= ctrl_r[shfs_pkg::CTRL_RATE];
      modeDual_r   <= ctrl_r[shfs_pkg::CTRL_DUAL];
      countSent_r  <= frameCount_r;
      frameCount_r <= frameCount_r + 1'b1;
      startPend_r  <= 1'b1;
    end
    else if (bitTick)
      startPend_r <= 1'b0;
  end

  // slot sequencing within the fixed-length frame
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      active_r <= 1'b0;
      slot_r   <= '0;
      bitIdx_r <= '0;
    end
    else if (bitTick)
    begin
      bitIdx_r <= wordLoad ? '0 : bitIdx_r + 1'b1;
      if (wordLoad && startPend_r)
      begin
        active_r <= 1'b1;
        slot_r   <= NW'(1);
      end
      else if (wordLoad)
      begin
        // frame ends after its constant slot count
        active_r <= active_r && (slot_r < frameSlots - 1'b1);
        slot_r   <= slot_r + 1'b1;
      end
    end
  end

  // shifters and lane pins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sh0_r          <= '0;
      sh1_r          <= '0;
      serial_lane0_r <= 1'b0;
      serial_lane1_r <= 1'b0;
    end
    else if (bitTick)
    begin
      // the start slot always loads the header, whatever slot_r held
      sh0_r          <= wordLoad ? (startPend_r ? openWord_r[WW-1:0] & {WW{modeDual_r}}
                                                : word0) >> 1
                                 : sh0_r >> 1;
      sh1_r          <= wordLoad ? (startPend_r ? (modeDual_r ? openWord_r[CW-1:WW]
                                                              : openWord_r[WW-1:0])
                                                : word1) >> 1
                                 : sh1_r >> 1;
      serial_lane0_r <= wordLoad ? (startPend_r ? openWord_r[0] & modeDual_r : word0[0])
                                 : sh0_r[0];
      serial_lane1_r <= wordLoad ? (startPend_r ? (modeDual_r ? openWord_r[WW] : openWord_r[0])
                                                : word1[0])
                                 : sh1_r[0];
    end
  end

  // frame marker, counted in fast bit times from the first bit
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      markCnt_r     <= '0;
      frameMarker_r <= 1'b0;
    end
    else if (bitTick && startPend_r)
    begin
      markCnt_r     <= 4'(shfs_pkg::MARK_TICKS - 1);
      frameMarker_r <= 1'b1;
    end
    else if (fastTick && (markCnt_r != '0))
      markCnt_r <= markCnt_r - 1'b1;
    else if (fastTick)
      frameMarker_r <= 1'b0;
  end

endmodule : shfs_serializer
